// [rtl/hvpwm_chan_if.sv]
`timescale 1ns/100ps
interface hvpwm_chan_if;
    logic [7:0] duty;
    logic       rate;
    logic       out;
    modport ctrl (output duty, output rate, input out);
    modport gen  (input duty, input rate, output out);
endinterface

// [rtl/hvpwm_channel.sv]
`timescale 1ns/100ps
`include "hvpwm_regs.svh"
module hvpwm_channel (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // Settings and output
    hvpwm_chan_if.gen   ch
);
    logic [16:0] tick_cnt;
    logic [7:0]  step;
    logic [16:0] tick_max;
    logic        tick;

    assign tick_max = ch.rate ? 17'(`HVPWM_TICK_FAST_CYC - 1) : 17'(`HVPWM_TICK_SLOW_CYC - 1);
    assign tick     = (tick_cnt >= tick_max);

    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt <= '0;
            step     <= '0;
            ch.out   <= 1'b0;
        end else if (ce) begin
            tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001;
            if (tick)
                step <= (step == 8'(`HVPWM_PWM_STEPS - 1)) ? 8'h00 : step + 8'h01;
            ch.out <= (step < ch.duty) || (ch.duty == 8'hFF);
        end
    end
endmodule

// [rtl/hvpwm_pkg.sv]
package hvpwm_pkg;
    typedef logic [7:0] hvpwm_byte_t;
    typedef enum logic [1:0] {
        HVPWM_FO_20,
        HVPWM_FO_10,
        HVPWM_FO_5,
        HVPWM_FO_2P5
    } hvpwm_fo_duty_t;
endpackage

// [rtl/hvpwm_regs.svh]
`ifndef HVPWM_REGS_SVH
`define HVPWM_REGS_SVH

// Register addresses (7-bit)
`define HVPWM_ADDR_PIN_CFG   7'h17
`define HVPWM_ADDR_DUTY1     7'h18
`define HVPWM_ADDR_DUTY2     7'h19
`define HVPWM_ADDR_FREQ      7'h1C

// Reset values
`define HVPWM_RST_BYTE       8'h00

// Field positions
`define HVPWM_FO_DUTY_HI     7
`define HVPWM_FO_DUTY_LO     6
`define HVPWM_PIN2_HI        5
`define HVPWM_PIN2_LO        3
`define HVPWM_PIN1_HI        2
`define HVPWM_PIN1_LO        0
`define HVPWM_CH1_RATE_BIT   0
`define HVPWM_CH2_RATE_BIT   2
`define HVPWM_FREQ_MASK      8'h05

// Pin function codes
`define HVPWM_FN_OFF         3'h4
`define HVPWM_FN_WAKE        3'h5
`define HVPWM_FN_LOW_SIDE    3'h6
`define HVPWM_FN_HIGH_SIDE   3'h7

// Timing
`define HVPWM_CLK_HZ         250000000
`define HVPWM_PWM_STEPS      255
`define HVPWM_SLOW_HZ        200
`define HVPWM_FAST_HZ        400
`define HVPWM_WAKE_FILT_NS   16000
`define HVPWM_CLK_NS         4
`define HVPWM_WAKE_FILT_CYC  (`HVPWM_WAKE_FILT_NS / `HVPWM_CLK_NS)
`define HVPWM_TICK_SLOW_CYC  (`HVPWM_CLK_HZ / (`HVPWM_SLOW_HZ * `HVPWM_PWM_STEPS))
`define HVPWM_TICK_FAST_CYC  (`HVPWM_CLK_HZ / (`HVPWM_FAST_HZ * `HVPWM_PWM_STEPS))
`define HVPWM_FO_PERIOD_CYC  40
`define HVPWM_FO_ON_20       3'h0
`define HVPWM_FO_ON_10       3'h1
`define HVPWM_FO_ON_5        3'h2
`define HVPWM_FO_ON_2P5      3'h3

`endif

// [rtl/hvpwm_top.sv]
`timescale 1ns/100ps
`include "hvpwm_regs.svh"
// What this block does
// - Duty field sets fail-output waveform duty
// - Pin field selects waveform, off, wake, switches
// - Channel one duty value over 255
// - Channel two uses same duty encoding
// - Rate bit selects 200 or 400 Hz
// - Reserved frequency bits read zero
// - Registers clear on reset and soft reset
// - Restart keeps pin and duty registers
module hvpwm_top (
    // Clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         soft_reset,
    input  wire logic         restart,
    // Register port
    input  wire logic [6:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    // Pin inputs
    input  wire logic         pin1_in,
    input  wire logic         pin2_in,
    // Pin and channel outputs
    output logic              fail_output_b,
    output logic              fail_output_c,
    output logic              pin1_low_side_on,
    output logic              pin2_low_side_on,
    output logic              pin1_high_side_switch_on,
    output logic              pin2_high_side_switch_on,
    output logic              pin1_wake,
    output logic              pin2_wake,
    output logic              pwm_ch1_out,
    output logic              pwm_ch2_out
);
    hvpwm_pkg::hvpwm_byte_t  pin_cfg;
    hvpwm_pkg::hvpwm_byte_t  duty1;
    hvpwm_pkg::hvpwm_byte_t  duty2;
    hvpwm_pkg::hvpwm_byte_t  freq;
    logic [2:0]              hv_pin1_function;
    logic [2:0]              hv_pin2_function;
    hvpwm_pkg::hvpwm_fo_duty_t fail_output_duty;
    logic [5:0]              fo_cnt;
    logic [5:0]              fo_on;
    logic                    fo_wave;
    logic [12:0]             filt1;
    logic [12:0]             filt2;
    logic                    next_wake1;
    logic                    next_wake2;
    logic [7:0]              next_rdata;
    logic                    clr;

    hvpwm_chan_if ch1 ();
    hvpwm_chan_if ch2 ();

    function automatic logic fn_is_fo(input logic [2:0] code);
        fn_is_fo = (code < `HVPWM_FN_OFF);
    endfunction

    function automatic logic [12:0] fn_filt(input logic [12:0] c, input logic en, input logic lvl,
                                            input logic st);
        if (!en || lvl == st)
            fn_filt = 13'h0000;
        else
            fn_filt = c + 13'h0001;
    endfunction

    assign clr              = rst || soft_reset;
    assign hv_pin1_function = pin_cfg[`HVPWM_PIN1_HI:`HVPWM_PIN1_LO];
    assign hv_pin2_function = pin_cfg[`HVPWM_PIN2_HI:`HVPWM_PIN2_LO];
    assign fail_output_duty = hvpwm_pkg::hvpwm_fo_duty_t'(pin_cfg[`HVPWM_FO_DUTY_HI:`HVPWM_FO_DUTY_LO]);

    // Fail-output on-time in 40-slot period
    always_comb begin
        unique case (fail_output_duty)
            hvpwm_pkg::HVPWM_FO_20:  fo_on = 6'h08;
            hvpwm_pkg::HVPWM_FO_10:  fo_on = 6'h04;
            hvpwm_pkg::HVPWM_FO_5:   fo_on = 6'h02;
            hvpwm_pkg::HVPWM_FO_2P5: fo_on = 6'h01;
        endcase
    end
    assign fo_wave = (fo_cnt < fo_on);

    assign ch1.duty = duty1;
    assign ch2.duty = duty2;
    assign ch1.rate = freq[`HVPWM_CH1_RATE_BIT];
    assign ch2.rate = freq[`HVPWM_CH2_RATE_BIT];

    assign next_wake1 = (filt1 >= 13'(`HVPWM_WAKE_FILT_CYC - 1)) ? pin1_in : pin1_wake;
    assign next_wake2 = (filt2 >= 13'(`HVPWM_WAKE_FILT_CYC - 1)) ? pin2_in : pin2_wake;

    always_comb begin
        unique case (reg_addr)
            `HVPWM_ADDR_PIN_CFG: next_rdata = pin_cfg;
            `HVPWM_ADDR_DUTY1:   next_rdata = duty1;
            `HVPWM_ADDR_DUTY2:   next_rdata = duty2;
            `HVPWM_ADDR_FREQ:    next_rdata = freq & `HVPWM_FREQ_MASK;
            default:             next_rdata = `HVPWM_RST_BYTE;
        endcase
    end

    // Registers; restart leaves them untouched
    always_ff @(posedge clk) begin
        if (clr) begin
            pin_cfg <= `HVPWM_RST_BYTE;
            duty1   <= `HVPWM_RST_BYTE;
            duty2   <= `HVPWM_RST_BYTE;
            freq    <= `HVPWM_RST_BYTE;
        end else if (ce && reg_wr) begin
            if (reg_addr == `HVPWM_ADDR_PIN_CFG)
                pin_cfg <= reg_wdata;
            if (reg_addr == `HVPWM_ADDR_DUTY1)
                duty1 <= reg_wdata;
            if (reg_addr == `HVPWM_ADDR_DUTY2)
                duty2 <= reg_wdata;
            if (reg_addr == `HVPWM_ADDR_FREQ)
                freq <= reg_wdata & `HVPWM_FREQ_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `HVPWM_RST_BYTE;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

    // Fail-output slot timer, one slot per slow-channel step
    logic [16:0] fo_tick;
    always_ff @(posedge clk) begin
        if (clr) begin
            fo_tick <= '0;
            fo_cnt  <= '0;
        end else if (ce) begin
            if (fo_tick >= 17'(`HVPWM_TICK_SLOW_CYC - 1)) begin
                fo_tick <= '0;
                fo_cnt  <= (fo_cnt == 6'(`HVPWM_FO_PERIOD_CYC - 1)) ? 6'h00 : fo_cnt + 6'h01;
            end else begin
                fo_tick <= fo_tick + 17'h00001;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge clk) begin
        if (clr) begin
            fail_output_b            <= 1'b0;
            fail_output_c            <= 1'b0;
            pin1_low_side_on         <= 1'b0;
            pin2_low_side_on         <= 1'b0;
            pin1_high_side_switch_on <= 1'b0;
            pin2_high_side_switch_on <= 1'b0;
            pwm_ch1_out              <= 1'b0;
            pwm_ch2_out              <= 1'b0;
        end else if (ce) begin
            fail_output_b            <= fn_is_fo(hv_pin1_function) && fo_wave;
            fail_output_c            <= fn_is_fo(hv_pin2_function) && fo_wave;
            pin1_low_side_on         <= (hv_pin1_function == `HVPWM_FN_LOW_SIDE);
            pin2_low_side_on         <= (hv_pin2_function == `HVPWM_FN_LOW_SIDE);
            pin1_high_side_switch_on <= (hv_pin1_function == `HVPWM_FN_HIGH_SIDE);
            pin2_high_side_switch_on <= (hv_pin2_function == `HVPWM_FN_HIGH_SIDE);
            pwm_ch1_out              <= ch1.out;
            pwm_ch2_out              <= ch2.out;
        end
    end

    // Static wake filter: level must hold 16 us
    always_ff @(posedge clk) begin
        if (clr) begin
            filt1     <= '0;
            filt2     <= '0;
            pin1_wake <= 1'b0;
            pin2_wake <= 1'b0;
        end else if (ce) begin
            filt1     <= fn_filt(filt1, hv_pin1_function == `HVPWM_FN_WAKE, pin1_in, pin1_wake);
            filt2     <= fn_filt(filt2, hv_pin2_function == `HVPWM_FN_WAKE, pin2_in, pin2_wake);
            pin1_wake <= (hv_pin1_function == `HVPWM_FN_WAKE) && next_wake1;
            pin2_wake <= (hv_pin2_function == `HVPWM_FN_WAKE) && next_wake2;
        end
    end

    hvpwm_channel u_ch1 (
        .clk (clk),
        .rst (clr),
        .ce  (ce),
        .ch  (ch1.gen)
    );

    hvpwm_channel u_ch2 (
        .clk (clk),
        .rst (clr),
        .ce  (ce),
        .ch  (ch2.gen)
    );

    logic unused_restart;
    assign unused_restart = restart;
endmodule

// [sim/hvpwm_top_chk.sv]
`timescale 1ns/100ps
module hvpwm_top_chk (
    // Clock and control
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       soft_reset,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Outputs
    input wire logic       fail_output_b,
    input wire logic       pin1_low_side_on,
    input wire logic       pin2_low_side_on,
    input wire logic       pin1_high_side_switch_on,
    input wire logic       pin1_wake,
    input wire logic       pwm_ch1_out,
    input wire logic       pwm_ch2_out
);
    logic [7:0] cfg;
    logic [7:0] cfg_d;
    logic [7:0] dty1;
    logic [7:0] dty2;
    wire  [7:0] next_cfg  = (reg_wr && reg_addr == 7'h17) ? reg_wdata : cfg;
    wire  [7:0] next_dty1 = (reg_wr && reg_addr == 7'h18) ? reg_wdata : dty1;
    wire  [7:0] next_dty2 = (reg_wr && reg_addr == 7'h19) ? reg_wdata : dty2;

    // Shadow copies of the pin and duty registers; cfg_d follows the registered outputs
    always_ff @(posedge clk) begin
        if (rst || soft_reset) begin
            cfg  <= 8'h00;
            dty1 <= 8'h00;
            dty2 <= 8'h00;
        end else if (ce) begin
            cfg  <= next_cfg;
            dty1 <= next_dty1;
            dty2 <= next_dty2;
        end
        if (ce || rst || soft_reset) begin
            cfg_d <= (rst || soft_reset) ? 8'h00 : cfg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LOW_SIDE: assert property (
        pin1_low_side_on == (cfg_d[2:0] == 3'h6) && pin2_low_side_on == (cfg_d[5:3] == 3'h6))
        else $error("Low-side switch disagrees with pin function");
    AST_HIGH_SIDE: assert property (
        pin1_high_side_switch_on == (cfg_d[2:0] == 3'h7))
        else $error("High-side switch disagrees with pin function");
    AST_FAIL_OFF: assert property (cfg_d[2] |-> !fail_output_b)
        else $error("Fail output active with a non-waveform code");
    AST_WAKE_GATE: assert property (cfg_d[2:0] != 3'h5 |-> !pin1_wake)
        else $error("Wake output active without wake code");
    AST_PWM1_OFF: assert property ((dty1 == 8'h00) [*4] |-> !pwm_ch1_out)
        else $error("Channel one on with zero duty");
    AST_PWM1_ON: assert property ((dty1 == 8'hFF) [*4] |-> pwm_ch1_out)
        else $error("Channel one off with full duty");
    AST_PWM2_ON: assert property ((dty2 == 8'hFF) [*4] |-> pwm_ch2_out)
        else $error("Channel two off with full duty");
    AST_FREQ_RSVD: assert property (
        reg_addr == 7'h1C && ce |=> (reg_rdata & 8'hFA) == 8'h00)
        else $error("Reserved frequency bits read nonzero");
    AST_DUTY_READ: assert property (
        reg_addr == 7'h18 && ce |=> reg_rdata == $past(dty1))
        else $error("Duty readback mismatch");

    cover property ($rose(pwm_ch1_out));
    cover property ($rose(pin1_wake));
    cover property (pin1_high_side_switch_on);
endmodule

bind hvpwm_top hvpwm_top_chk i_chk (.clk, .rst, .ce, .soft_reset, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .fail_output_b, .pin1_low_side_on, .pin2_low_side_on,
    .pin1_high_side_switch_on, .pin1_wake, .pwm_ch1_out, .pwm_ch2_out);

// [sim/test_hvpwm_top.sv]
`timescale 1ns/100ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_hvpwm_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        soft_reset = 1'b0;
    logic        restart = 1'b0;
    logic [6:0]  reg_addr = 7'h1A;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        pin1_in = 1'b0;
    logic [7:0]  reg_rdata, e, d, rv[4];
    logic        p1ls, p2ls, p1hs, p2hs, p1wk, p2wk, pwm1, pwm2;
    logic [31:0] seed = 32'h41;
    logic [7:0]  q[$];
    logic [6:0]  adr[4] = '{7'h17, 7'h18, 7'h19, 7'h1C};
    logic [2:0]  cd[4] = '{3'h4, 3'h5, 3'h6, 3'h7};
    logic        rd_v = 1'b0;
    logic        rd_d = 1'b0;
    logic        ob_v = 1'b0;
    logic        fo_v = 1'b0;
    logic        fob, foc;
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;
    wire  [7:0]  outs = {p1ls, p2ls, p1hs, p2hs, p1wk, p2wk, pwm1, pwm2};

    hvpwm_top i_dut (.clk, .rst, .ce(1'b1), .soft_reset, .restart, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rdata, .pin1_in, .pin2_in(1'b0), .fail_output_b(fob),
        .fail_output_c(foc), .pin1_low_side_on(p1ls), .pin2_low_side_on(p2ls),
        .pin1_high_side_switch_on(p1hs), .pin2_high_side_switch_on(p2hs),
        .pin1_wake(p1wk), .pin2_wake(p2wk), .pwm_ch1_out(pwm1), .pwm_ch2_out(pwm2));

    always #2 clk = ~clk;

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Kind 1 write, 2 read, 3 output check, 4 fail-output check, 0 idle
    task automatic op(input int k, input logic [6:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= (k == 1);
        reg_wdata <= x;
        rd_v <= (k == 2);
        ob_v <= (k == 3);
        fo_v <= (k == 4);
        if (k > 1) q.push_back(x);
    endtask

    task automatic idle(input int n);
        repeat (n) op(0, 7'h1A, 8'h00);
    endtask

    task automatic pulse_soft_reset();
        soft_reset <= 1'b1;
        op(0, 7'h1A, 8'h00);
        soft_reset <= 1'b0;
    endtask

    always @(posedge clk) begin
        rd_d <= rd_v;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // Oldest note is compared with read data, the output bundle or the fail-output pair
    always @(negedge clk) begin
        if (rd_d || ob_v || fo_v) begin
            e = q.pop_front();
            `CMP(rd_d ? reg_rdata : (ob_v ? outs : {6'h00, fob, foc}), e)
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (adr[i]) op(2, adr[i], 8'h00);
        op(1, 7'h1A, 8'hFF);
        op(2, 7'h1A, 8'h00);
        repeat (6) foreach (adr[i]) begin
            d = rnd();
            rv[i] = (i == 3) ? d & 8'h05 : d;
            op(1, adr[i], d);
            op(2, adr[i], rv[i]);
        end
        restart <= 1'b1;
        idle(3);
        restart <= 1'b0;
        foreach (adr[i]) op(2, adr[i], rv[i]);
        pulse_soft_reset();
        foreach (adr[i]) op(2, adr[i], 8'h00);
        foreach (cd[i]) begin
            op(1, 7'h17, {2'b00, cd[3 - i], cd[i]});
            idle(2);
            op(3, 7'h1A, {cd[i] == 3'h6, cd[3 - i] == 3'h6, cd[i] == 3'h7,
                cd[3 - i] == 3'h7, 4'h0});
        end
        op(1, 7'h17, 8'h2D);
        pin1_in <= 1'b1;
        idle(3900);
        op(3, 7'h1A, 8'h00);
        idle(200);
        op(3, 7'h1A, 8'h08);
        op(1, 7'h17, 8'h24);
        op(1, 7'h18, 8'hFF);
        idle(4);
        op(3, 7'h1A, 8'h02);
        op(1, 7'h18, 8'h00);
        op(1, 7'h19, 8'hFF);
        idle(4);
        op(3, 7'h1A, 8'h01);
        pulse_soft_reset();
        op(1, 7'h1C, 8'h01);
        op(1, 7'h18, 8'h01);
        op(1, 7'h19, 8'h01);
        idle(2000);
        op(3, 7'h1A, 8'h03);
        idle(1000);
        op(3, 7'h1A, 8'h01);
        pulse_soft_reset();
        op(1, 7'h17, 8'hC0);
        idle(2000);
        op(4, 7'h1A, 8'h03);
        idle(3500);
        op(4, 7'h1A, 8'h00);
        idle(2);
        wrap_up();
    end
endmodule
